/* logic/hsp_defines.svh */
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH

// register offsets
`define HSP_OFF_DAC_FAST 8'h2e
`define HSP_OFF_RATIO 8'h30
`define HSP_OFF_TRIP_STATUS 8'h31
`define HSP_OFF_STRAP_STATUS 8'h32
`define HSP_OFF_RANGE 8'h33
`define HSP_OFF_CHAN_EN 8'h3b

// reset values
`define HSP_RST_DAC_FAST 8'hbf
`define HSP_RST_RATIO 4'hf
`define HSP_RST_CHAN_EN 4'h0
`define HSP_RST_RANGE 4'h0

// field positions
`define HSP_BIT_EN_A 0
`define HSP_BIT_EN_B 1
`define HSP_BIT_PIN 0
`define HSP_BIT_PROT_LO 6
`define HSP_BIT_PROT_HI 7

// sense range codes and protection codes
`define HSP_RANGE_25MV 2'b10
`define HSP_RANGE_50MV 2'b01
`define HSP_RANGE_100MV 2'b00
`define HSP_PROT_ALERT 2'b00
`define HSP_PROT_ALERT_PG 2'b01
`define HSP_PROT_SHUTDOWN 2'b10

// slow-trip timing at the base overdrive
`define HSP_CLK_PERIOD_NS 8
`define HSP_SLOW_TRIP_NS 2000
`define HSP_SLOW_TRIP_CYC ((`HSP_SLOW_TRIP_NS) / (`HSP_CLK_PERIOD_NS))

`endif

/* logic/hsp_pkg.sv */
package hsp_pkg;
  // channel control states
  typedef enum logic [1:0] {
    HSP_CH_OFF,
    HSP_CH_ON,
    HSP_CH_LATCHED
  } hsp_state_t;

  // sense level and thresholds, 1023 is about 100 mV across the resistor
  typedef logic [9:0] hsp_level_t;
  typedef logic [7:0] hsp_byte_t;
endpackage

/* logic/hsp_trip_if.sv */
`timescale 1ns/10ps
interface hsp_trip_if;
  import hsp_pkg::*;
  hsp_level_t sense;
  hsp_byte_t dac;
  logic [1:0] range;
  logic [1:0] ratio;
  hsp_level_t fast_th;
  hsp_level_t slow_th;
  logic fast_over;
  logic slow_over;
  logic timer_run;
  logic slow_expired;

  modport calc (input sense, dac, range, ratio, output fast_th, slow_th, fast_over, slow_over);
  modport timer (input sense, slow_th, slow_over, timer_run, output slow_expired);
  modport ctrl (output sense, dac, range, ratio, timer_run,
                input fast_th, slow_th, fast_over, slow_over, slow_expired);
endinterface

/* logic/hsp_threshold_calc.sv */
`timescale 1ns/10ps
`include "hsp_defines.svh"
module hsp_threshold_calc (
  hsp_trip_if.calc trip // thresholds and comparator results
);
  import hsp_pkg::*;

  logic [11:0] fast_wide;
  logic [11:0] slow_wide;

  // fast threshold: dac code scaled into the chosen full-scale range
  assign fast_wide = (trip.range == `HSP_RANGE_25MV) ? {4'h0, trip.dac} :
                     (trip.range == `HSP_RANGE_50MV) ? {3'h0, trip.dac, 1'b0} :
                     {2'h0, trip.dac, 2'b00}; // see R11
  assign trip.fast_th = fast_wide[9:0];

  // slow threshold = fast / ratio, so fast stays the higher one for any nonzero dac code
  assign slow_wide = (trip.ratio == 2'b00) ? (fast_wide * 12'd4) / 12'd5 :
                     (trip.ratio == 2'b01) ? (fast_wide * 12'd2) / 12'd3 :
                     (trip.ratio == 2'b10) ? (fast_wide * 12'd4) / 12'd7 :
                     fast_wide >> 1; // see R13 see R16
  assign trip.slow_th = slow_wide[9:0];

  // digital stand-ins for the two analog comparators
  assign trip.fast_over = trip.sense > trip.fast_th; // see R10
  assign trip.slow_over = trip.sense > trip.slow_th; // see R10
endmodule

/* logic/hsp_slow_timer.sv */
`timescale 1ns/10ps
`include "hsp_defines.svh"
module hsp_slow_timer (
  input wire logic mclk_in, // system clock
  input wire logic arst_n_in, // async reset, active low
  hsp_trip_if.timer trip // slow comparator in, expiry out
);
  import hsp_pkg::*;

  // bigger overdrive gives a shorter terminal count
  function automatic logic [7:0] terminal_count(input hsp_level_t od);
    logic [7:0] base;
    base = 8'(`HSP_SLOW_TRIP_CYC);
    if (od >= 10'd256) terminal_count = base >> 4;
    else if (od >= 10'd64) terminal_count = base >> 2;
    else if (od >= 10'd16) terminal_count = base >> 1;
    else terminal_count = base;
  endfunction

  logic [7:0] count;
  hsp_level_t overdrive;
  logic [7:0] limit;

  assign overdrive = trip.slow_over ? hsp_level_t'(trip.sense - trip.slow_th) : 10'h000;
  assign limit = terminal_count(overdrive); // see R14 see R19

  // a dip below the threshold restarts the wait, so short bumps never trip
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= 8'h00;
    end else if (!trip.slow_over || !trip.timer_run) begin
      count <= 8'h00; // see R14
    end else if (count != 8'hff) begin
      count <= count + 8'h01;
    end
  end

  assign trip.slow_expired = trip.slow_over && (count >= limit); // see R19
endmodule

/* logic/hsp_channel_top.sv */
`timescale 1ns/10ps
`include "hsp_defines.svh"
// Function
// R1 - two software enable bits plus enable pin gate the channel
// R2 - enable register bits 3:2 writable spare, bits 7:4 read zero
// R3 - strap status bit 0 shows enable pin level, bit 1 reads zero
// R4 - strap status register is read-only; bits 7:6 show protection strap
// R5 - protection 00: critical voltage event only raises alert
// R6 - protection 01: critical event raises alert and drops power-good
// R7 - protection 10: alert, drop power-good and switch channel off
// R8 - protection field never holds 11
// R9 - gate fully on only when all turn-on conditions hold together
// R10 - gate stays on below both trip levels; exceeding either shuts down
// R11 - fast-trip level is 8-bit code within one of three ranges
// R12 - software keeps fast code between 40 and 100 percent of range
// R13 - slow level derived from fast by selected ratio, always lower
// R14 - small brief slow overcurrent ignored; delay shrinks with overdrive
// R15 - ratio register bits 1:0, reset 0x0f, bits 3:2 spare, 7:4 read zero
// R16 - ratio codes 00,01,10,11 give 125,150,175,200 percent
// R17 - sense range loaded from strap after reset, software may rewrite
// R18 - overcurrent shutdown drives the open-drain fault pin
// R19 - slow trip uses overdrive-dependent counter; fast trip bypasses it
// R20 - channel on needs both bits, pin high and no latched shutdown
module hsp_channel_top (
  input wire logic mclk_in, // 125 MHz system clock
  input wire logic arst_n_in, // async reset, active low
  input wire logic [7:0] addr_in, // register address
  input wire logic [7:0] wdata_in, // register write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [7:0] rdata_out, // read data, cycle after rd_in
  input wire logic enable_pin_in, // enable pin above its threshold
  input wire logic [1:0] prot_strap_in, // decoded protection strap
  input wire logic [1:0] sense_range_strap_in, // decoded range strap
  input wire hsp_pkg::hsp_level_t sense_level_in, // sensed current level
  input wire logic warning_event_in, // any warning-level event
  input wire logic undervoltage_event_in, // critical undervoltage
  input wire logic overvoltage_event_in, // critical overvoltage
  output logic gate_on_out, // external switch gate on
  output logic alert_out, // alert level, active high
  output logic power_good_out, // power good, active high
  input wire logic fault_pin_in, // fault wire level, unused inside
  output logic fault_pin_out, // fault drive value, always low
  output logic fault_pin_oe_out // fault pulls low while high
);
  import hsp_pkg::*;

  // a read strobe with a mapped address returns that register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // a three-state range strap cannot give 11; fold it to the widest range
  // so the threshold path never sees a scale it does not know
  function automatic logic [1:0] fold_range(input logic [1:0] code);
    fold_range = (code == 2'b11) ? `HSP_RANGE_100MV : code;
  endfunction

  hsp_trip_if trip ();

  // register storage
  hsp_byte_t dac_fast;
  logic [3:0] ratio_bits;
  logic [3:0] range_bits;
  logic [3:0] chan_en_bits;
  logic [1:0] prot_sel;
  logic strap_taken;

  // channel control
  hsp_state_t state;
  hsp_state_t next_state;
  logic oc_latched;
  logic next_oc_latched;
  logic enable_ok;
  logic crit_event;
  logic crit_kill;
  logic crit_pg_drop;
  logic oc_trip;
  logic next_gate_on;
  logic next_alert;
  logic next_power_good;

  // register port decode
  logic wr_dac;
  logic wr_ratio;
  logic wr_range;
  logic wr_chan_en;
  logic sel_dac;
  logic sel_ratio;
  logic sel_trip;
  logic sel_strap;
  logic sel_range;
  logic sel_chan_en;
  logic [3:0] range_wr_value;
  hsp_byte_t trip_status;
  hsp_byte_t strap_status;
  hsp_byte_t read_value;
  hsp_byte_t next_rdata;
  logic [1:0] prot_clean;
  logic [1:0] range_clean;

  // address decode, shared by the write strobes and the read mux
  assign sel_dac = hit(addr_in, `HSP_OFF_DAC_FAST);
  assign sel_ratio = hit(addr_in, `HSP_OFF_RATIO);
  assign sel_trip = hit(addr_in, `HSP_OFF_TRIP_STATUS);
  assign sel_strap = hit(addr_in, `HSP_OFF_STRAP_STATUS);
  assign sel_range = hit(addr_in, `HSP_OFF_RANGE);
  assign sel_chan_en = hit(addr_in, `HSP_OFF_CHAN_EN);

  // status views get no write strobe, so writes to them simply vanish
  assign wr_dac = wr_in && sel_dac;
  assign wr_ratio = wr_in && sel_ratio;
  assign wr_range = wr_in && sel_range;
  assign wr_chan_en = wr_in && sel_chan_en;

  // strap decode: a three-state strap cannot give 11, so fold it safely
  assign prot_clean = (prot_strap_in == 2'b11) ? `HSP_PROT_SHUTDOWN : prot_strap_in; // see R8
  assign range_clean = fold_range(sense_range_strap_in); // see R17

  // software range write: spare bits kept, code 11 folded like the strap
  assign range_wr_value = {wdata_in[3:2], fold_range(wdata_in[1:0])}; // see R17

  // dac code for the fast trip level
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dac_fast <= `HSP_RST_DAC_FAST;
    end else if (wr_dac) begin
      dac_fast <= wdata_in; // see R11
    end
  end

  // ratio select, upper nibble is not stored and reads zero
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ratio_bits <= `HSP_RST_RATIO; // see R15
    end else if (wr_ratio) begin
      ratio_bits <= wdata_in[3:0]; // see R15
    end
  end

  // channel enable bits, spare bits 3:2 keep what is written
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      chan_en_bits <= `HSP_RST_CHAN_EN;
    end else if (wr_chan_en) begin
      chan_en_bits <= wdata_in[3:0]; // see R1 see R2
    end
  end

  // straps are caught once, on the first edge after reset release;
  // the strap load wins over a write arriving on that same edge
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_taken <= 1'b0;
      prot_sel <= `HSP_PROT_ALERT;
      range_bits <= `HSP_RST_RANGE;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      prot_sel <= prot_clean; // see R4 see R8
      range_bits <= {2'b00, range_clean}; // see R17
    end else if (wr_range) begin
      range_bits <= range_wr_value; // see R17
    end
  end

  // feed the threshold path; range 11 is never stored, so no odd scale
  assign trip.sense = sense_level_in;
  assign trip.dac = dac_fast;
  assign trip.range = range_bits[1:0];
  assign trip.ratio = ratio_bits[1:0]; // see R16
  assign trip.timer_run = (state == HSP_CH_ON);

  hsp_threshold_calc u_calc (
    .trip(trip)
  );

  hsp_slow_timer u_timer (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .trip(trip)
  );

  // turn-on conditions and fault responses
  assign enable_ok = chan_en_bits[`HSP_BIT_EN_A] && chan_en_bits[`HSP_BIT_EN_B]
                     && enable_pin_in; // see R1 see R20
  assign crit_event = undervoltage_event_in || overvoltage_event_in;
  assign crit_kill = crit_event && (prot_sel == `HSP_PROT_SHUTDOWN); // see R7
  assign crit_pg_drop = crit_event && (prot_sel != `HSP_PROT_ALERT); // see R5 see R6 see R7
  // fast trip acts at once, the slow one only after its timer runs out
  assign oc_trip = trip.fast_over || trip.slow_expired; // see R10 see R19

  // channel state machine; a latched shutdown holds until the enables drop
  always_comb begin
    next_state = state;
    next_oc_latched = oc_latched;
    case (state)
      HSP_CH_OFF: begin
        next_oc_latched = 1'b0;
        if (enable_ok && !crit_kill) begin
          next_state = HSP_CH_ON; // see R9 see R20
        end
      end
      HSP_CH_ON: begin
        if (!enable_ok) begin
          next_state = HSP_CH_OFF;
        end else if (oc_trip) begin
          next_state = HSP_CH_LATCHED; // see R10
          next_oc_latched = 1'b1; // see R18
        end else if (crit_kill) begin
          next_state = HSP_CH_LATCHED; // see R7
        end
      end
      HSP_CH_LATCHED: begin
        if (!enable_ok) begin
          next_state = HSP_CH_OFF; // see R20
          next_oc_latched = 1'b0;
        end
      end
      default: begin
        next_state = HSP_CH_OFF;
        next_oc_latched = 1'b0;
      end
    endcase
  end

  // outputs follow the next state so the gate drops on the trip edge itself
  assign next_gate_on = (next_state == HSP_CH_ON); // see R9 see R10
  assign next_alert = warning_event_in || crit_event; // see R5
  assign next_power_good = next_gate_on && !crit_pg_drop; // see R6

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= HSP_CH_OFF;
      oc_latched <= 1'b0;
    end else begin
      state <= next_state;
      oc_latched <= next_oc_latched;
    end
  end

  // channel pin outputs, registered so no decode glitch reaches the gate
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gate_on_out <= 1'b0;
      alert_out <= 1'b0;
      power_good_out <= 1'b0;
    end else begin
      gate_on_out <= next_gate_on;
      alert_out <= next_alert;
      power_good_out <= next_power_good;
    end
  end

  // fault pin: open drain, so only the enable carries information
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_pin_out <= 1'b0;
      fault_pin_oe_out <= 1'b0;
    end else begin
      fault_pin_out <= 1'b0; // open drain only ever pulls low
      fault_pin_oe_out <= next_oc_latched; // see R18
    end
  end

  // read-only status views
  assign trip_status = {5'h00, oc_latched, trip.fast_over, trip.slow_over};

  // strap status from the field positions; unused bits read zero
  always_comb begin
    strap_status = 8'h00;
    strap_status[`HSP_BIT_PIN] = enable_pin_in; // see R3
    strap_status[`HSP_BIT_PROT_HI] = prot_sel[1]; // see R4
    strap_status[`HSP_BIT_PROT_LO] = prot_sel[0]; // see R4
  end

  // read mux; unmapped addresses and writes to read-only ones are ignored
  assign read_value = sel_dac ? dac_fast :
                      sel_ratio ? {4'h0, ratio_bits} :
                      sel_trip ? trip_status :
                      sel_strap ? strap_status :
                      sel_range ? {4'h0, range_bits} :
                      sel_chan_en ? {4'h0, chan_en_bits} : // see R2
                      8'h00;
  assign next_rdata = rd_in ? read_value : 8'h00;

  // read data stands for one cycle only and is zero otherwise
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= next_rdata;
    end
  end
endmodule

/* dv/hsp_channel_top_assertions.sv */
`timescale 1ns/10ps
module hsp_chan_chk (
  input wire logic mclk_in, // clock
  input wire logic arst_n_in, // reset
  input wire logic [7:0] addr_in, // address
  input wire logic rd_in, // read strobe
  input wire logic [7:0] rdata_out, // read data
  input wire logic enable_pin_in, // enable pin
  input wire logic [1:0] prot_strap_in, // protection strap
  input wire logic warning_event_in, // warning
  input wire logic undervoltage_event_in, // critical low
  input wire logic overvoltage_event_in, // critical high
  input wire logic gate_on_out, // gate
  input wire logic alert_out, // alert
  input wire logic power_good_out, // power good
  input wire logic fault_pin_oe_out // fault pull
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  // strap code 11 acts as 10, so fold it before comparing a read
  wire crit = undervoltage_event_in | overvoltage_event_in;
  wire evt = crit | warning_event_in;
  wire prot_lo = prot_strap_in[0] & ~prot_strap_in[1];
  wire [7:0] strap_rd = {prot_strap_in[1], prot_lo, 5'h00, enable_pin_in};
  a_alert_set: assert property (evt |=> alert_out)
    else $error("alert missing");
  a_pg_crit: assert property (crit && prot_strap_in != 2'b00 |=> !power_good_out)
    else $error("power good held");
  a_gate_crit: assert property (crit && prot_strap_in[1] |=> !gate_on_out)
    else $error("gate held on");
  a_pg_gate: assert property (power_good_out |-> gate_on_out)
    else $error("power good, gate off");
  a_pin_low: assert property (!enable_pin_in |=> !gate_on_out)
    else $error("gate on, pin low");
  a_strap_read: assert property (rd_in && addr_in == 8'h32 |=> rdata_out == $past(strap_rd))
    else $error("strap read wrong");
  a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("stray read data");
  a_fault_trip: assert property ($rose(fault_pin_oe_out) |-> !gate_on_out)
    else $error("fault with gate on");
endmodule
bind hsp_channel_top hsp_chan_chk u_chk (
  .mclk_in(mclk_in),
  .arst_n_in(arst_n_in),
  .addr_in(addr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .enable_pin_in(enable_pin_in),
  .prot_strap_in(prot_strap_in),
  .warning_event_in(warning_event_in),
  .undervoltage_event_in(undervoltage_event_in),
  .overvoltage_event_in(overvoltage_event_in),
  .gate_on_out(gate_on_out),
  .alert_out(alert_out),
  .power_good_out(power_good_out),
  .fault_pin_oe_out(fault_pin_oe_out)
);

/* dv/hsp_fet_model.sv */
`timescale 1ns/10ps
module hsp_fet_model (
  input wire logic gate_in, // gate drive
  input wire hsp_pkg::hsp_level_t load_in, // load asked for
  input wire logic fault_oe_in, // fault pull
  output hsp_pkg::hsp_level_t sense_out, // sense level
  output logic fault_wire_out // fault wire
);
  import hsp_pkg::*;
  // a switch that is off carries no current
  assign sense_out = gate_in ? load_in : '0;
  // pull-up holds the wire high when released
  assign fault_wire_out = fault_oe_in ? 1'b0 : 1'b1;
endmodule

/* dv/hsp_channel_top_tb.sv */
`timescale 1ns/10ps
module hsp_channel_top_tb;
  import hsp_pkg::*;
  logic clk, rst_n, wr, rd, pin, warn, uv, ov, gate, alert, pg, f_oe, f_wire, f_out;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] prot, ep, rs;
  hsp_level_t sense, load;
  int fail_count, total_checks, n;
  // slow levels per ratio at fast code 0xbf on the 100 mV range
  hsp_level_t slow_th [4] = '{10'd611, 10'd509, 10'd436, 10'd382};
  int od [4] = '{1, 16, 64, 256};
  int lim [4] = '{250, 125, 62, 15};
  hsp_channel_top dut (.mclk_in(clk), .arst_n_in(rst_n), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .enable_pin_in(pin), .prot_strap_in(prot), .sense_range_strap_in(rs),
    .sense_level_in(sense), .warning_event_in(warn), .undervoltage_event_in(uv),
    .overvoltage_event_in(ov), .gate_on_out(gate), .alert_out(alert),
    .power_good_out(pg), .fault_pin_in(f_wire), .fault_pin_out(f_out),
    .fault_pin_oe_out(f_oe));
  hsp_fet_model fet (.gate_in(gate), .load_in(load), .fault_oe_in(f_oe),
    .sense_out(sense), .fault_wire_out(f_wire));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdchk(string nm, logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
    chk(nm, e, d);
  endtask
  // first request waits two edges so it is not lost to the strap capture;
  // the range strap follows the protection strap code
  task automatic do_reset(logic [1:0] p);
    @(posedge clk);
    rst_n <= 0;
    prot <= p;
    rs <= p;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    cyc(2);
  endtask
  // turn on, apply a load and count cycles until the gate drops
  task automatic trip_time(hsp_level_t lvl);
    wr_reg(8'h3b, 8'h03);
    cyc(3);
    @(posedge clk);
    load <= lvl;
    n = 0;
    while (gate === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    @(posedge clk);
    load <= '0;
    wr_reg(8'h3b, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_regs();
    do_reset(2'b00);
    rdchk("dac_rst", 8'h2e, 8'hbf);
    rdchk("ratio_rst", 8'h30, 8'h0f);
    rdchk("en_rst", 8'h3b, 8'h00);
    wr_reg(8'h30, 8'hf6);
    rdchk("ratio_wr", 8'h30, 8'h06);
    wr_reg(8'h3b, 8'hf8);
    rdchk("en_wr", 8'h3b, 8'h08);
    wr_reg(8'h32, 8'hfe);
    rdchk("strap_ro", 8'h32, 8'h01);
    rdchk("range_strap", 8'h33, 8'h00);
    wr_reg(8'h33, 8'h0f);
    rdchk("range_wr", 8'h33, 8'h0c);
    rdchk("unmapped", 8'h10, 8'h00);
    $display("regs done");
  endtask
  task automatic t_enable();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      pin <= (i != 4);
      wr_reg(8'h3b, (i == 4) ? 8'h03 : i[7:0]);
      cyc(3);
      chk("gate_en", i == 3, gate);
      chk("pg_en", i == 3, pg);
      rdchk("pin_state", 8'h32, {7'h00, i != 4});
    end
    wr_reg(8'h3b, 8'h00);
    pin <= 1;
    $display("enable done");
  endtask
  // strap 11 must act and read back as 10
  task automatic t_prot();
    for (int p = 0; p < 4; p++) begin
      ep = p[1] ? 2'b10 : p[1:0];
      do_reset(p[1:0]);
      rdchk("prot", 8'h32, {ep, 6'h01});
      rdchk("range_fold", 8'h33, {6'h00, (p == 3) ? 2'b00 : p[1:0]});
      wr_reg(8'h3b, 8'h03);
      @(posedge clk);
      warn <= 1;
      cyc(3);
      chk("warn_pg", 1, pg);
      @(posedge clk);
      warn <= 0;
      uv <= !p[0];
      ov <= p[0];
      cyc(2);
      chk("crit_alert", 1, alert);
      chk("crit_pg", ep == 2'b00, pg);
      chk("crit_gate", ep != 2'b10, gate);
      @(posedge clk);
      uv <= 0;
      ov <= 0;
      cyc(2);
      chk("alert_clr", 0, alert);
    end
    $display("prot done");
  endtask
  // at the fast level the slow count is too short to trip yet
  task automatic t_fast();
    do_reset(2'b00);
    wr_reg(8'h2e, 8'hbf);
    for (int r = 0; r < 2; r++) begin
      wr_reg(8'h33, r ? 8'h02 : 8'h00);
      wr_reg(8'h3b, 8'h03);
      cyc(3);
      @(posedge clk);
      load <= r ? 10'd191 : 10'd764;
      cyc(5);
      chk("at_fast", 1, gate);
      @(posedge clk);
      load <= r ? 10'd192 : 10'd765;
      cyc(2);
      chk("fast_gate", 0, gate);
      chk("fault_low", 0, f_wire);
      chk("fault_drv", 0, f_out);
      rdchk("trip_status", 8'h31, 8'h04);
      wr_reg(8'h3b, 8'h00);
      load <= '0;
      cyc(2);
      chk("fault_free", 1, f_wire);
    end
    $display("fast done");
  endtask
  task automatic t_slow();
    wr_reg(8'h33, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h30, k[7:0]);
      trip_time(slow_th[k]);
      chk("at_slow", 400, n);
      trip_time(slow_th[k] + 10'd1);
      chk("ratio_delay", 1, n >= 248 && n <= 253);
    end
    for (int j = 0; j < 4; j++) begin
      trip_time(10'd382 + od[j][9:0]);
      chk("od_delay", 1, n >= lim[j] - 2 && n <= lim[j] + 3);
    end
    wr_reg(8'h3b, 8'h03);
    for (int b = 0; b < 3; b++) begin
      @(posedge clk);
      load <= (b == 1) ? 10'd382 : 10'd383;
      cyc(b == 1 ? 2 : 200);
    end
    chk("brief_over", 1, gate);
    $display("slow done");
  endtask
  initial begin
    {rst_n, wr, rd, warn, uv, ov} = '0;
    addr = '0;
    wdata = '0;
    pin = 1;
    prot = '0;
    rs = '0;
    load = '0;
    t_regs();
    t_enable();
    t_prot();
    t_fast();
    t_slow();
    report_and_stop();
  end
  // the full run needs well under half this span
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule
